// *** hw/tss_cfg.svh ***
// register map, field positions and reset values of the touch state block
`ifndef TSS_CFG_SVH
`define TSS_CFG_SVH
// register byte offsets
`define TSS_OFF_SPREAD     8'h60
`define TSS_OFF_ARES       8'h64
`define TSS_OFF_BRES       8'h68
`define TSS_OFF_BASE_CNT   8'h6c
`define TSS_OFF_CURR_CNT   8'h70
`define TSS_OFF_TSW        8'h78
`define TSS_OFF_TSR        8'h7c
`define TSS_OFF_FLAGS      8'h80
`define TSS_OFF_FLAGCLR    8'h84
`define TSS_OFF_SSTAT      8'ha0
`define TSS_OFF_PAIRS      8'hf8
// field positions
`define TSS_DEV_LIMIT_MSB  7
`define TSS_SKIPCAL_BIT    24
`define TSS_DETECT_MSB     23
`define TSS_DETECT_LSB     16
`define TSS_BASELINE_MSB   15
`define TSS_FLG_WRREQ_BIT  16
`define TSS_FLG_RDRDY_BIT  17
`define TSS_FLG_SSCHG_BIT  23
// writable masks and reset values
`define TSS_STATE_MASK     32'h01ffffff
`define TSS_RST_WORD       32'h00000000
`define TSS_RST_DEV_LIMIT  8'h00
`define TSS_PAIRS_DEFAULT  32'h01ffffff
`endif

// *** hw/tss_pkg.sv ***
// types shared by the touch state register block
package tss_pkg;
   typedef logic [31:0] tss_word_t;
   // write data phase progress on the register bus
   typedef enum logic [1:0] {
      TSS_BP_IDLE,
      TSS_BP_WRITE,
      TSS_BP_DONE
   } tss_bphase_e;
endpackage

// *** hw/tss_burst_dev.sv ***
// pseudo random burst pulse deviation bounded by the maximum deviation
`timescale 1ns/1ps
`include "tss_cfg.svh"
module tss_burst_dev
   import tss_pkg::*;
#(
   parameter int DEV_W = 8
) (
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire logic                  spread_en,
   input  wire logic [DEV_W-1:0]      max_deviation,
   input  wire logic                  pulse_start,
   output logic signed [DEV_W:0]      burst_deviation
);
   initial begin
      if (DEV_W < 1 || DEV_W > 15) $error("DEV_W out of range");
   end

   logic [15:0]      lfsr_r;     // free running noise source
   logic [DEV_W-1:0] mag;        // magnitude, never above max_deviation

   // 16-bit maximal length shift register, never all zero
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lfsr_r <= 16'hace1;
      end else begin
         lfsr_r <= {lfsr_r[14:0],
                    lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      end
   end

   // masking by the limit keeps the magnitude at or below it
   assign mag = lfsr_r[DEV_W-1:0] & max_deviation;

   // a new deviation is chosen at each pulse start, zero when spread is off
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         burst_deviation <= '0;
      end else if (pulse_start) begin
         if (!spread_en) begin
            burst_deviation <= '0;
         end else if (lfsr_r[15]) begin
            burst_deviation <= -$signed({1'b0, mag});
         end else begin
            burst_deviation <= $signed({1'b0, mag});
         end
      end
   end

   a_dev_bounded: assert property (@(posedge clk_sys) disable iff (rst)
      $rose(pulse_start) |=> ((burst_deviation <= $signed({1'b0,
         $past(max_deviation)})) && (burst_deviation >= -$signed({1'b0,
         $past(max_deviation)}))))
      else $error("burst deviation exceeds limit");
endmodule

// *** hw/tss_regs.sv ***
// touch state registers: ahb-lite slave, drive control and state exchange
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`include "tss_cfg.svh"
module tss_regs
   import tss_pkg::*;
#(
   parameter int        NUM_PINS   = 17,
   parameter int        DEV_W      = 8,
   parameter tss_word_t PAIRS_MASK = `TSS_PAIRS_DEFAULT
) (
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   // ahb-lite slave
   input  wire logic                 hsel,
   input  wire logic [7:0]           haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic                      hresp,
   output logic [31:0]               hrdata,
   // burst engine
   input  wire logic                 spread_en,
   input  wire logic                 burst_active,
   input  wire logic                 pulse_start,
   output logic signed [DEV_W:0]     burst_deviation,
   output logic [NUM_PINS-1:0]       sense_line_a_res,
   output logic [NUM_PINS-1:0]       sense_line_b_res,
   // autonomous sensor counts
   input  wire logic [15:0]          at_base_count,
   input  wire logic [15:0]          at_curr_count,
   // tracking engine exchange
   input  wire logic                 trk_wr_need,
   input  wire logic                 trk_rd_valid,
   input  wire logic [31:0]          trk_rd_word,
   input  wire logic                 trk_status_valid,
   input  wire logic [31:0]          trk_status_word,
   output logic                      trk_wr_valid,
   output logic [31:0]               trk_wr_word,
   output logic                      state_write_request,
   output logic                      state_read_ready,
   output logic                      sensor_state_change
);
   initial begin
      if (NUM_PINS < 1 || NUM_PINS > 32) $error("NUM_PINS out of range");
      if (DEV_W < 1 || DEV_W > 15) $error("DEV_W out of range");
   end

   localparam tss_word_t RES_MASK = tss_word_t'((64'd1 << NUM_PINS) - 1);

   tss_bphase_e           bphase_r;         // bus data phase progress
   logic [7:0]            waddr_r;          // address held for a write
   logic                  accept;           // address phase taken
   logic                  wr_strobe;        // write commits this edge
   logic                  rd_accept;        // read address phase taken
   logic [DEV_W-1:0]      max_deviation_r;  // spread limit
   logic [NUM_PINS-1:0]   res_a_r;          // a-line resistive enables
   logic [NUM_PINS-1:0]   res_b_r;          // b-line resistive enables
   logic [15:0]           base_cnt_r;       // sampled baseline count
   logic [15:0]           curr_cnt_r;       // sampled current count
   tss_word_t             tsr_r;            // readable state word
   tss_word_t             sstat_r;          // per sensor pushed bits
   tss_word_t             rd_mux;           // read data selection
   tss_word_t             flags_word;       // flag register image
   logic                  wr_tsw;           // state write register hit
   logic                  wr_tsr;           // state read register hit
   logic                  wr_fclr;          // flag clear register hit
   logic                  rd_tsr;           // state read register read

   // ---------------- bus slave ----------------

   // address phase is taken only while the bus is ready
   assign accept    = hsel && htrans[1] && hready;
   assign rd_accept = accept && !hwrite;

   // writes take one wait state so a following read sees new data
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         bphase_r <= TSS_BP_IDLE;
         waddr_r  <= 8'h00;
      end else begin
         case (bphase_r)
            TSS_BP_IDLE: begin
               if (accept && hwrite) begin
                  bphase_r <= TSS_BP_WRITE;
                  waddr_r  <= haddr;
               end
            end
            TSS_BP_WRITE: begin
               bphase_r <= TSS_BP_DONE;
            end
            TSS_BP_DONE: begin
               if (accept && hwrite) begin
                  bphase_r <= TSS_BP_WRITE;
                  waddr_r  <= haddr;
               end else begin
                  bphase_r <= TSS_BP_IDLE;
               end
            end
            default: begin
               bphase_r <= TSS_BP_IDLE;
            end
         endcase
      end
   end

   // hready low only in the cycle the write data are taken
   assign hreadyout = (bphase_r != TSS_BP_WRITE);
   assign hresp     = 1'b0;
   assign wr_strobe = (bphase_r == TSS_BP_WRITE);

   // register hits on the write side, plus the state read register read
   assign wr_tsw  = wr_strobe && (waddr_r == `TSS_OFF_TSW);
   assign wr_tsr  = wr_strobe && (waddr_r == `TSS_OFF_TSR);
   assign wr_fclr = wr_strobe && (waddr_r == `TSS_OFF_FLAGCLR);
   assign rd_tsr  = rd_accept && (haddr == `TSS_OFF_TSR);

   // ---------------- configuration registers ----------------

   // spread limit and resistive drive enables, reserved bits dropped
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         max_deviation_r <= DEV_W'(`TSS_RST_DEV_LIMIT);
         res_a_r         <= '0;
         res_b_r         <= '0;
      end else if (wr_strobe) begin
         if (waddr_r == `TSS_OFF_SPREAD) begin
            max_deviation_r <= hwdata[DEV_W-1:0];
         end
         if (waddr_r == `TSS_OFF_ARES) begin
            res_a_r <= hwdata[NUM_PINS-1:0];
         end
         if (waddr_r == `TSS_OFF_BRES) begin
            res_b_r <= hwdata[NUM_PINS-1:0];
         end
      end
   end

   // deviation generator for spread spectrum bursting
   tss_burst_dev #(
      .DEV_W           (DEV_W)
   ) u_dev (
      .clk_sys         (clk_sys),
      .rst             (rst),
      .spread_en       (spread_en),
      .max_deviation   (max_deviation_r),
      .pulse_start     (pulse_start),
      .burst_deviation (burst_deviation)
   );

   // resistive drive follows the burst one cycle later, one per pin
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               sense_line_a_res[gi] <= 1'b0;
               sense_line_b_res[gi] <= 1'b0;
            end else begin
               sense_line_a_res[gi] <= res_a_r[gi] && burst_active;
               sense_line_b_res[gi] <= res_b_r[gi] && burst_active;
            end
         end
      end
   endgenerate

   // ---------------- autonomous sensor counts ----------------

   // counts are sampled every cycle for debug reading
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         base_cnt_r <= 16'h0000;
         curr_cnt_r <= 16'h0000;
      end else begin
         base_cnt_r <= at_base_count;
         curr_cnt_r <= at_curr_count;
      end
   end

   // ---------------- state word exchange ----------------

   // software state word passes to the engine with a one cycle strobe
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         trk_wr_valid <= 1'b0;
         trk_wr_word  <= `TSS_RST_WORD;
      end else begin
         trk_wr_valid <= wr_tsw;
         if (wr_tsw) begin
            // flag, detection count and baseline kept, rest zero
            trk_wr_word <= hwdata & `TSS_STATE_MASK;
         end
      end
   end

   // readable state word: engine update wins over a software write
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tsr_r <= `TSS_RST_WORD;
      end else if (trk_rd_valid) begin
         tsr_r <= trk_rd_word & `TSS_STATE_MASK;
      end else if (wr_tsr) begin
         tsr_r <= hwdata & `TSS_STATE_MASK;
      end
   end

   // write request: set by engine, cleared by a state word write
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_write_request <= 1'b0;
      end else if (trk_wr_need) begin
         state_write_request <= 1'b1;
      end else if (wr_tsw) begin
         state_write_request <= 1'b0;
      end
   end

   // read ready: set on new word, cleared when software reads it
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_read_ready <= 1'b0;
      end else if (trk_rd_valid) begin
         state_read_ready <= 1'b1;
      end else if (rd_tsr) begin
         state_read_ready <= 1'b0;
      end
   end

   // ---------------- sensor status ----------------

   // pushed bits follow the engine's status updates
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sstat_r <= `TSS_RST_WORD;
      end else if (trk_status_valid) begin
         sstat_r <= trk_status_word;
      end
   end

   // change flag is sticky; a change wins over a clear in one cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sensor_state_change <= 1'b0;
      end else if (trk_status_valid && (trk_status_word != sstat_r)) begin
         sensor_state_change <= 1'b1;
      end else if (wr_fclr && hwdata[`TSS_FLG_SSCHG_BIT]) begin
         sensor_state_change <= 1'b0;
      end
   end

   // ---------------- read path ----------------

   // flags at their status word bit positions
   always_comb begin
      flags_word                     = '0;
      flags_word[`TSS_FLG_WRREQ_BIT] = state_write_request;
      flags_word[`TSS_FLG_RDRDY_BIT] = state_read_ready;
      flags_word[`TSS_FLG_SSCHG_BIT] = sensor_state_change;
   end

   // read selection; write-only and unmapped addresses read zero
   always_comb begin
      case (haddr)
         `TSS_OFF_SPREAD:   rd_mux = tss_word_t'(max_deviation_r);
         `TSS_OFF_ARES:     rd_mux = tss_word_t'(res_a_r) & RES_MASK;
         `TSS_OFF_BRES:     rd_mux = tss_word_t'(res_b_r) & RES_MASK;
         `TSS_OFF_BASE_CNT: rd_mux = {16'h0000, base_cnt_r};
         `TSS_OFF_CURR_CNT: rd_mux = {16'h0000, curr_cnt_r};
         `TSS_OFF_TSR:      rd_mux = tsr_r;
         `TSS_OFF_FLAGS:    rd_mux = flags_word;
         `TSS_OFF_SSTAT:    rd_mux = sstat_r;
         `TSS_OFF_PAIRS:    rd_mux = PAIRS_MASK;
         default:           rd_mux = '0;
      endcase
   end

   // read data registered at the end of the address phase
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hrdata <= 32'h00000000;
      end else if (rd_accept) begin
         hrdata <= rd_mux;
      end
   end

   // ---------------- checks ----------------

   sequence s_tsw_write;
      wr_tsw;
   endsequence

   sequence s_word_out;
      trk_wr_valid && (trk_wr_word == $past(hwdata & `TSS_STATE_MASK));
   endsequence

   a_pin_a_burst: assert property (@(posedge clk_sys) disable iff (rst)
      ##1 sense_line_a_res ==
         ($past(res_a_r) & {NUM_PINS{$past(burst_active)}}))
      else $error("a-line drive does not follow enable and burst");

   a_pin_b_idle: assert property (@(posedge clk_sys) disable iff (rst)
      !burst_active [*2] |-> sense_line_b_res == '0)
      else $error("b-line resistive outside burst");

   a_base_read: assert property (@(posedge clk_sys) disable iff (rst)
      (rd_accept && haddr == `TSS_OFF_BASE_CNT) |=>
         hrdata == {16'h0000, $past(base_cnt_r)})
      else $error("baseline count read wrong");

   a_curr_track: assert property (@(posedge clk_sys) disable iff (rst)
      ##1 curr_cnt_r == $past(at_curr_count))
      else $error("current count not sampled");

   a_word_pass: assert property (@(posedge clk_sys) disable iff (rst)
      s_tsw_write |=> s_word_out ##1 (!trk_wr_valid || wr_tsw))
      else $error("state word not passed to engine");

   a_tsr_load: assert property (@(posedge clk_sys) disable iff (rst)
      trk_rd_valid |=> tsr_r == ($past(trk_rd_word) & `TSS_STATE_MASK)
         && state_read_ready)
      else $error("state read word not loaded");

   a_stat_load: assert property (@(posedge clk_sys) disable iff (rst)
      trk_status_valid |=> sstat_r == $past(trk_status_word))
      else $error("sensor status not updated");

   a_wrreq_hold: assert property (@(posedge clk_sys) disable iff (rst)
      (trk_wr_need ##1 (!wr_tsw && !trk_wr_need)) |->
         state_write_request)
      else $error("write request lost");

   a_rdrdy_clear: assert property (@(posedge clk_sys) disable iff (rst)
      (rd_tsr && !trk_rd_valid) |=> !state_read_ready)
      else $error("read ready not cleared by read");

   a_change_set: assert property (@(posedge clk_sys) disable iff (rst)
      (trk_status_valid && trk_status_word != sstat_r) |=>
         sensor_state_change)
      else $error("status change flag not set");

   a_pairs_read: assert property (@(posedge clk_sys) disable iff (rst)
      (rd_accept && haddr == `TSS_OFF_PAIRS) |=> hrdata == PAIRS_MASK)
      else $error("implemented pairs read wrong");

   a_tsw_reads0: assert property (@(posedge clk_sys) disable iff (rst)
      (rd_accept && haddr == `TSS_OFF_TSW) |=> hrdata == 32'h00000000)
      else $error("write-only register reads nonzero");
endmodule

// *** verification/tss_engine_model.sv ***
// model of the tracking engine and autonomous sensor beside the block
`timescale 1ns/1ps
module tss_engine_model (
   input  wire logic        clk_sys,
   input  wire logic        trk_wr_valid,
   input  wire logic [31:0] trk_wr_word,
   output logic             trk_wr_need,
   output logic             trk_rd_valid,
   output logic [31:0]      trk_rd_word,
   output logic             trk_status_valid,
   output logic [31:0]      trk_status_word,
   output logic [15:0]      at_base_count,
   output logic [15:0]      at_curr_count
);
   logic [31:0] got_word;  // last state word handed over by software
   // quiet outputs at time zero
   initial begin
      trk_wr_need      = 1'b0;
      trk_rd_valid     = 1'b0;
      trk_rd_word      = 32'h0;
      trk_status_valid = 1'b0;
      trk_status_word  = 32'h0;
      at_base_count    = 16'h0;
      at_curr_count    = 16'h0;
      got_word         = 32'h0;
   end
   // take a state word in the cycle it is handed over
   always @(posedge clk_sys) begin
      if (trk_wr_valid === 1'b1) begin
         got_word <= trk_wr_word;
      end
   end
   // ask software for a fresh state word, one cycle
   task automatic ask_word();
      trk_wr_need <= 1'b1;
      @(posedge clk_sys);
      trk_wr_need <= 1'b0;
   endtask
   // offer a new state word; the word lines scramble once released
   task automatic send_word(input logic [31:0] w);
      trk_rd_valid <= 1'b1;
      trk_rd_word  <= w;
      @(posedge clk_sys);
      trk_rd_valid <= 1'b0;
      trk_rd_word  <= ~w;
   endtask
   // publish the pushed bits of all sensors
   task automatic send_status(input logic [31:0] s);
      trk_status_valid <= 1'b1;
      trk_status_word  <= s;
      @(posedge clk_sys);
      trk_status_valid <= 1'b0;
      trk_status_word  <= ~s;
   endtask
   // new base and current counts from the autonomous sensor
   task automatic set_counts(input logic [15:0] b, input logic [15:0] c);
      at_base_count <= b;
      at_curr_count <= c;
   endtask
endmodule

// *** verification/tb.sv ***
// self-checking bench for the touch state register block
`timescale 1ns/1ps
`include "tss_cfg.svh"
module tb
   import tss_pkg::*;
();
   logic              clk_sys, rst, hsel, hwrite, hready, hreadyout;
   logic [7:0]        haddr;
   logic [1:0]        htrans;
   logic [2:0]        hsize;
   tss_word_t         hwdata, hrdata, trk_rd_word, trk_status_word;
   logic              hresp, spread_en, burst_active, pulse_start;
   logic signed [8:0] burst_deviation;
   logic [16:0]       sense_line_a_res, sense_line_b_res;
   logic [15:0]       at_base_count, at_curr_count, b16, c16;
   logic              trk_wr_need, trk_rd_valid, trk_status_valid;
   logic              trk_wr_valid, state_write_request;
   logic              state_read_ready, sensor_state_change;
   tss_word_t         trk_wr_word, w, ra, rb, e, obs;
   logic [7:0]        md;
   tss_word_t         exp_q[$];  // expectations, oldest first
   event              obs_ev;    // a result is ready in obs
   int                miscompares = 0;
   int                comparisons = 0;
   integer            seed = 32'he626;
   // register addresses with reset value zero, plus flags and a hole
   logic [7:0] z_addr [10] = '{8'h60, 8'h64, 8'h68, 8'h6c, 8'h70,
                               8'h78, 8'h7c, 8'ha0, 8'h80, 8'h74};
   logic [7:0] rw_addr [3] = '{8'h60, 8'h64, 8'h68};
   tss_word_t  rw_mask [3] = '{32'hff, 32'h1ffff, 32'h1ffff};
   logic [7:0] ro_addr [4] = '{8'h6c, 8'h70, 8'ha0, 8'hf8};
   tss_word_t  ro_exp  [4] = '{32'h0, 32'h0, 32'h0, `TSS_PAIRS_DEFAULT};
   tss_word_t  tsr_val [2] = '{32'hffffffff, 32'h00abcdef};
   // single slave: its ready is the bus ready
   assign hready = hreadyout;
   tss_regs tss_regs_inst (
      .clk_sys             (clk_sys),
      .rst                 (rst),
      .hsel                (hsel),
      .haddr               (haddr),
      .htrans              (htrans),
      .hwrite              (hwrite),
      .hsize               (hsize),
      .hwdata              (hwdata),
      .hready              (hready),
      .hreadyout           (hreadyout),
      .hresp               (hresp),
      .hrdata              (hrdata),
      .spread_en           (spread_en),
      .burst_active        (burst_active),
      .pulse_start         (pulse_start),
      .burst_deviation     (burst_deviation),
      .sense_line_a_res    (sense_line_a_res),
      .sense_line_b_res    (sense_line_b_res),
      .at_base_count       (at_base_count),
      .at_curr_count       (at_curr_count),
      .trk_wr_need         (trk_wr_need),
      .trk_rd_valid        (trk_rd_valid),
      .trk_rd_word         (trk_rd_word),
      .trk_status_valid    (trk_status_valid),
      .trk_status_word     (trk_status_word),
      .trk_wr_valid        (trk_wr_valid),
      .trk_wr_word         (trk_wr_word),
      .state_write_request (state_write_request),
      .state_read_ready    (state_read_ready),
      .sensor_state_change (sensor_state_change)
   );
   tss_engine_model tss_engine_model_inst (
      .clk_sys          (clk_sys),
      .trk_wr_valid     (trk_wr_valid),
      .trk_wr_word      (trk_wr_word),
      .trk_wr_need      (trk_wr_need),
      .trk_rd_valid     (trk_rd_valid),
      .trk_rd_word      (trk_rd_word),
      .trk_status_valid (trk_status_valid),
      .trk_status_word  (trk_status_word),
      .at_base_count    (at_base_count),
      .at_curr_count    (at_curr_count)
   );
   // 40 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // note an expectation and hand the observed value to the watcher
   task automatic chk(input tss_word_t ex, input tss_word_t act);
      exp_q.push_back(ex);
      obs = act;
      -> obs_ev;
   endtask
   // compare each result with the oldest note
   initial begin
      forever begin
         @(obs_ev);
         comparisons++;
         e = exp_q.pop_front();
         if (e !== obs) begin
            $display("Error t=%0t exp=%h act=%h", $time, e, obs);
            miscompares++;
         end
      end
   end
   // wait for an edge with ready sampled high
   task automatic wait_rdy();
      do @(posedge clk_sys); while (hready !== 1'b1);
   endtask
   // one word write on the register bus
   task automatic bus_wr(input logic [7:0] a, input tss_word_t d);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= 1'b1;
      haddr  <= a;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
   endtask
   // one word read, checked against ex
   task automatic bus_rd(input logic [7:0] a, input tss_word_t ex);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= 1'b0;
      haddr  <= a;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'b00;
      wait_rdy();
      chk(ex, hrdata);
   endtask
   // deviation magnitude within the limit
   function automatic logic dev_ok(input logic signed [8:0] d,
                                   input logic [7:0] m);
      logic [8:0] mag;
      mag = d[8] ? 9'(-d) : 9'(d);
      return mag <= {1'b0, m};
   endfunction
   // print the verdict and stop
   task automatic final_report();
      if (miscompares == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // cut a hang short
   initial begin
      repeat (5000) @(posedge clk_sys);
      miscompares++;
      final_report();
   end
   // main sequence
   initial begin
      rst = 1'b1; hsel = 1'b0; htrans = 2'b00; hwrite = 1'b0;
      haddr = 8'h0; hsize = 3'b010; hwdata = 32'h0; spread_en = 1'b0;
      burst_active = 1'b0; pulse_start = 1'b0;
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      // reset values, flags and an unmapped hole
      foreach (z_addr[i]) bus_rd(z_addr[i], 32'h0);
      // read-write fields keep only their assigned bits
      for (int i = 0; i < 3; i++) begin
         w = $random(seed);
         bus_wr(rw_addr[i], w);
         bus_rd(rw_addr[i], w & rw_mask[i]);
      end
      // read-only places ignore writes
      foreach (ro_addr[i]) begin
         bus_wr(ro_addr[i], $random(seed));
         bus_rd(ro_addr[i], ro_exp[i]);
      end
      // resistive drive only while bursting
      ra = $random(seed);
      rb = $random(seed);
      bus_wr(8'h64, ra);
      bus_wr(8'h68, rb);
      burst_active <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk(ra & 32'h1ffff, {15'h0, sense_line_a_res});
      @(posedge clk_sys);
      chk(rb & 32'h1ffff, {15'h0, sense_line_b_res});
      burst_active <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk(32'h0, {15'h0, sense_line_a_res | sense_line_b_res});
      // burst pulse deviation bounded by the limit
      md = $random(seed);
      bus_wr(8'h60, {24'h0, md});
      spread_en <= 1'b1;
      repeat (16) begin
         pulse_start <= 1'b1;
         @(posedge clk_sys);
         pulse_start <= 1'b0;
         @(posedge clk_sys);
         chk(32'h1, {31'h0, dev_ok(burst_deviation, md)});
      end
      spread_en   <= 1'b0;
      pulse_start <= 1'b1;
      @(posedge clk_sys);
      pulse_start <= 1'b0;
      @(posedge clk_sys);
      chk(32'h0, {23'h0, burst_deviation});
      // autonomous sensor counts
      b16 = $random(seed);
      c16 = $random(seed);
      tss_engine_model_inst.set_counts(b16, c16);
      @(posedge clk_sys);
      bus_rd(8'h6c, {16'h0, b16});
      bus_rd(8'h70, {16'h0, c16});
      // engine asks for a word, software writes it
      tss_engine_model_inst.ask_word();
      bus_rd(8'h80, 32'h00010000);
      w = $random(seed);
      bus_wr(8'h78, w);
      @(posedge clk_sys);
      chk(w & `TSS_STATE_MASK, tss_engine_model_inst.got_word);
      bus_rd(8'h80, 32'h0);
      bus_rd(8'h78, 32'h0);
      // engine offers a word, software reads it
      w = $random(seed);
      tss_engine_model_inst.send_word(w);
      bus_rd(8'h80, 32'h00020000);
      bus_rd(8'h7c, w & `TSS_STATE_MASK);
      bus_rd(8'h80, 32'h0);
      // pushed bits and their change flag
      w = $random(seed) | 32'h1;
      tss_engine_model_inst.send_status(w);
      bus_rd(8'ha0, w);
      bus_rd(8'h80, 32'h00800000);
      bus_wr(8'h84, 32'h00800000);
      bus_rd(8'h80, 32'h0);
      tss_engine_model_inst.send_status(w);
      bus_rd(8'h80, 32'h0);
      tss_engine_model_inst.send_status(w ^ 32'h80000000);
      bus_rd(8'ha0, w ^ 32'h80000000);
      bus_rd(8'h80, 32'h00800000);
      // software write of the readable word, read back masked
      foreach (tsr_val[i]) begin
         bus_wr(8'h7c, tsr_val[i]);
         bus_rd(8'h7c, tsr_val[i] & `TSS_STATE_MASK);
      end
      @(posedge clk_sys);
      final_report();
   end
endmodule
